// >>> rtxt_defs.vh
// constants for the transmit and receive timing register block
`ifndef RTXT_DEFS_VH
`define RTXT_DEFS_VH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define RTXT_IDX_PROTO 6'h01
`define RTXT_IDX_TMR_HI 6'h04
`define RTXT_IDX_TMR_LO 6'h05
`define RTXT_IDX_PULSE 6'h06
`define RTXT_IDX_NORESP 6'h07
`define RTXT_IDX_STATUS 6'h0C

// ****************************************
// reset and preset values
// ****************************************
`define RTXT_RST_PROTO 4'hF
`define RTXT_RST_TMR_HI 8'hC2
`define RTXT_RST_TMR_LO 8'h00
`define RTXT_RST_PULSE 8'h00
`define RTXT_RST_NORESP 8'h0E
`define RTXT_NORESP_HDR 8'h14
`define RTXT_NORESP_LDR 8'h30

// ****************************************
// protocol codes and field positions
// ****************************************
`define RTXT_P_15693_LDR 4'h0
`define RTXT_P_15693_HDR 4'h1
`define RTXT_P_14443A_106 4'h2
`define RTXT_P_14443A_212 4'h3
`define RTXT_P_14443A_424 4'h4
`define RTXT_P_14443A_848 4'h5
`define RTXT_TRIG_MSB 7
`define RTXT_TRIG_LSB 6
`define RTXT_LEN_HI_MSB 5
`define RTXT_TRIG_TX_SOF_BEGIN 2'h0
`define RTXT_TRIG_TX_SOF_END 2'h1
`define RTXT_TRIG_RX_SOF_BEGIN 2'h2
`define RTXT_TRIG_RX_SOF_END 2'h3
`define RTXT_ST_FLAG 0
`define RTXT_ST_DELAY 1
`define RTXT_ST_SILENCE 2
`define RTXT_ST_PULSE 3

// ****************************************
// timing, times in picoseconds
// ****************************************
`define RTXT_CLK_PERIOD_PS 10000
`define RTXT_DELAY_STEP_PS 590000
`define RTXT_DELAY_STEP_CYC (`RTXT_DELAY_STEP_PS / `RTXT_CLK_PERIOD_PS)
`define RTXT_SILENCE_STEP_PS 37760000
`define RTXT_SILENCE_STEP_CYC (`RTXT_SILENCE_STEP_PS / `RTXT_CLK_PERIOD_PS)
`define RTXT_PULSE_STEP_PS 73700
`define RTXT_PULSE_15693_PS 9440000
`define RTXT_PULSE_106_PS 2360000
`define RTXT_PULSE_212_PS 1400000
`define RTXT_PULSE_424_PS 737000
`define RTXT_PULSE_848_PS 442000

`endif

// >>> rtxt_timing_regs.v
// transmit and receive timing registers with delay, pulse and silence timers
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "rtxt_defs.vh"

module rtxt_timing_regs (
  input wire clk,
  input wire reset,
  input wire enable,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire txStartReq,
  input wire txSofBegin,
  input wire txSofEnd,
  input wire rxSofBegin,
  input wire rxSofEnd,
  input wire txEofEnd,
  input wire tagResponseStart,
  input wire modStart,
  output reg txLaunch,
  output reg modPulse,
  output reg silenceIrq
);

  // ****************************************
  // helpers
  // ****************************************
  function [20:0] delayCycles;
    input [13:0] len;
    reg [31:0] p;
    begin
      p = len * `RTXT_DELAY_STEP_CYC;
      delayCycles = p[20:0];
    end
  endfunction

  function [11:0] psToCycles;
    input [31:0] ps;
    reg [31:0] c;
    begin
      c = (ps + `RTXT_CLK_PERIOD_PS - 1) / `RTXT_CLK_PERIOD_PS;
      psToCycles = c[11:0];
    end
  endfunction

  function isMapped;
    input [5:0] idx;
    begin
      isMapped = (idx == `RTXT_IDX_PROTO) || (idx == `RTXT_IDX_TMR_HI) || (idx == `RTXT_IDX_TMR_LO) ||
        (idx == `RTXT_IDX_PULSE) || (idx == `RTXT_IDX_NORESP) || (idx == `RTXT_IDX_STATUS);
    end
  endfunction

  localparam DLY_IDLE = 2'b00;
  localparam DLY_ARMED = 2'b01;
  localparam DLY_COUNT = 2'b10;

  reg [3:0] protoSel;
  reg [7:0] timerHigh;
  reg [7:0] timerLow;
  reg [7:0] pulseLen;
  reg [7:0] silenceWait;
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;
  reg [1:0] dlyState;
  reg [20:0] dlyCnt;
  reg silenceRun;
  reg [11:0] stepCnt;
  reg [7:0] stepNum;
  reg [11:0] pulseCnt;
  reg presetPending;

  // ****************************************
  // bus decode
  // ****************************************
  wire [5:0] wIdx = awAddrQ[7:2];
  wire [5:0] rIdx = s_axi_araddr[7:2];
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wMapped = isMapped(wIdx) && (awAddrQ[1:0] == 2'h0);
  wire wAct = doWrite && wMapped && wStrbQ[0] && enable;
  wire protoWrite = wAct && (wIdx == `RTXT_IDX_PROTO);
  wire readTake = s_axi_arvalid && !s_axi_rvalid;
  wire readStatus = readTake && (rIdx == `RTXT_IDX_STATUS) && (s_axi_araddr[1:0] == 2'h0);
  wire is15693 = (protoSel == `RTXT_P_15693_LDR) || (protoSel == `RTXT_P_15693_HDR);

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire [13:0] delayLen = {timerHigh[`RTXT_LEN_HI_MSB:0], timerLow};
  wire [1:0] trigSel = timerHigh[`RTXT_TRIG_MSB:`RTXT_TRIG_LSB];
  wire [7:0] statusWord = {4'h0, modPulse, silenceRun, dlyState != DLY_IDLE, silenceIrq};

  reg [7:0] next_silenceWait;
  always @* begin
    case (protoSel)
      `RTXT_P_15693_HDR: next_silenceWait = `RTXT_NORESP_HDR;
      `RTXT_P_15693_LDR: next_silenceWait = `RTXT_NORESP_LDR;
      default: next_silenceWait = `RTXT_RST_NORESP;
    endcase
  end

  reg [7:0] readByte;
  always @* begin
    case (rIdx)
      `RTXT_IDX_PROTO: readByte = {4'h0, protoSel};
      `RTXT_IDX_TMR_HI: readByte = timerHigh;
      `RTXT_IDX_TMR_LO: readByte = timerLow;
      `RTXT_IDX_PULSE: readByte = pulseLen;
      `RTXT_IDX_NORESP: readByte = silenceWait;
      `RTXT_IDX_STATUS: readByte = statusWord;
      default: readByte = 8'h00;
    endcase
  end

  // ****************************************
  // bus handshakes
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (readTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (isMapped(rIdx) && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        s_axi_rdata <= {24'h000000, readByte};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // timing registers
  // ****************************************
  // the silence timeout gets its protocol preset one cycle after the protocol write
  always @(posedge clk) begin
    presetPending <= protoWrite;
    if (reset || !enable) begin
      protoSel <= `RTXT_RST_PROTO;
      timerHigh <= `RTXT_RST_TMR_HI;
      timerLow <= `RTXT_RST_TMR_LO;
      pulseLen <= `RTXT_RST_PULSE;
      silenceWait <= `RTXT_RST_NORESP;
    end else if (protoWrite) begin
      protoSel <= wDataQ[3:0];
      timerHigh <= `RTXT_RST_TMR_HI;
      timerLow <= `RTXT_RST_TMR_LO;
      pulseLen <= `RTXT_RST_PULSE;
      silenceWait <= `RTXT_RST_NORESP;
    end else if (wAct) begin
      case (wIdx)
        `RTXT_IDX_TMR_HI: timerHigh <= wDataQ[7:0];
        `RTXT_IDX_TMR_LO: timerLow <= wDataQ[7:0];
        `RTXT_IDX_PULSE: pulseLen <= wDataQ[7:0];
        `RTXT_IDX_NORESP: silenceWait <= wDataQ[7:0];
        default: silenceWait <= silenceWait;
      endcase
    end else if (presetPending) begin
      silenceWait <= next_silenceWait;
    end
  end

  // ****************************************
  // delayed transmission timer
  // ****************************************
  reg trigHit;
  always @* begin
    case (trigSel)
      `RTXT_TRIG_TX_SOF_BEGIN: trigHit = txSofBegin;
      `RTXT_TRIG_TX_SOF_END: trigHit = txSofEnd;
      `RTXT_TRIG_RX_SOF_BEGIN: trigHit = rxSofBegin;
      default: trigHit = rxSofEnd;
    endcase
  end

  always @(posedge clk) begin
    if (reset || !enable) begin
      dlyState <= DLY_IDLE;
      dlyCnt <= 21'h00000;
      txLaunch <= 1'b0;
    end else begin
      txLaunch <= 1'b0;
      case (dlyState)
        DLY_IDLE: begin
          if (txStartReq) begin
            if (delayLen == 14'h0000) begin
              txLaunch <= 1'b1;
            end else begin
              dlyState <= DLY_ARMED;
            end
          end
        end
        DLY_ARMED: begin
          if (trigHit) begin
            dlyState <= DLY_COUNT;
            dlyCnt <= 21'h00001;
          end
        end
        DLY_COUNT: begin
          if (dlyCnt >= delayCycles(delayLen)) begin
            txLaunch <= 1'b1;
            dlyState <= DLY_IDLE;
          end else begin
            dlyCnt <= dlyCnt + 21'h00001;
          end
        end
        default: dlyState <= DLY_IDLE;
      endcase
    end
  end

  // ****************************************
  // modulation pulse length
  // ****************************************
  reg [11:0] protoPulse;
  always @* begin
    case (protoSel)
      `RTXT_P_14443A_106: protoPulse = psToCycles(`RTXT_PULSE_106_PS);
      `RTXT_P_14443A_212: protoPulse = psToCycles(`RTXT_PULSE_212_PS);
      `RTXT_P_14443A_424: protoPulse = psToCycles(`RTXT_PULSE_424_PS);
      `RTXT_P_14443A_848: protoPulse = psToCycles(`RTXT_PULSE_848_PS);
      default: protoPulse = psToCycles(`RTXT_PULSE_15693_PS);
    endcase
  end

  // rounded up so a programmed pulse is never shorter than asked
  wire [11:0] pulseTarget = (pulseLen == 8'h00) ? protoPulse :
    psToCycles(pulseLen * `RTXT_PULSE_STEP_PS);

  always @(posedge clk) begin
    if (reset || !enable) begin
      pulseCnt <= 12'h000;
      modPulse <= 1'b0;
    end else if (modStart && !modPulse) begin
      pulseCnt <= pulseTarget;
      modPulse <= 1'b1;
    end else if (modPulse) begin
      if (pulseCnt <= 12'h001) begin
        modPulse <= 1'b0;
        pulseCnt <= 12'h000;
      end else begin
        pulseCnt <= pulseCnt - 12'h001;
      end
    end
  end

  // ****************************************
  // no-response timer
  // ****************************************
  wire silenceDone = silenceRun && !tagResponseStart && (stepCnt == `RTXT_SILENCE_STEP_CYC - 1) &&
    (stepNum + 8'h01 == silenceWait);

  always @(posedge clk) begin
    if (reset || !enable) begin
      silenceRun <= 1'b0;
      stepCnt <= 12'h000;
      stepNum <= 8'h00;
    end else if (txEofEnd && is15693 && silenceWait != 8'h00) begin
      silenceRun <= 1'b1;
      stepCnt <= 12'h000;
      stepNum <= 8'h00;
    end else if (silenceRun) begin
      if (tagResponseStart || silenceDone) begin
        silenceRun <= 1'b0;
      end else if (stepCnt == `RTXT_SILENCE_STEP_CYC - 1) begin
        stepCnt <= 12'h000;
        stepNum <= stepNum + 8'h01;
      end else begin
        stepCnt <= stepCnt + 12'h001;
      end
    end
  end

  // sticky flag, a timeout in the clearing cycle keeps it set
  always @(posedge clk) begin
    if (reset || !enable) begin
      silenceIrq <= 1'b0;
    end else if (silenceDone) begin
      silenceIrq <= 1'b1;
    end else if (readStatus) begin
      silenceIrq <= 1'b0;
    end
  end

endmodule // rtxt_timing_regs

// >>> rtxt_timing_chk.sv
// assertions on the ports of the timing register block
`timescale 1ns/1ns
module rtxt_timing_chk (
  input wire clk,
  input wire reset,
  input wire enable,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire modStart,
  input wire txLaunch,
  input wire modPulse,
  input wire silenceIrq
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a status read may clear the flag, so stickiness is only claimed without one
  wire stTake = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h30;
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_bad;
    s_rd ##0 s_axi_araddr == 8'hFC;
  endsequence
  property p_launch; txLaunch |=> !txLaunch; endproperty
  property p_enable; !enable |=> !txLaunch && !modPulse && !silenceIrq; endproperty
  property p_mod; modStart && !modPulse && enable |=> modPulse; endproperty
  property p_modMin; $rose(modPulse) |-> modPulse [*8]; endproperty
  property p_sticky; silenceIrq && enable && !stTake |=> silenceIrq; endproperty
  property p_rdAns; s_rd |=> s_axi_rvalid; endproperty
  property p_unmap; s_bad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_launch: assert property (p_launch) else $error("launch longer than one cycle");
  a_enable: assert property (p_enable) else $error("outputs active with enable low");
  a_mod: assert property (p_mod) else $error("pulse did not start");
  a_modMin: assert property (p_modMin) else $error("pulse shorter than one step");
  a_sticky: assert property (p_sticky) else $error("silence flag lost");
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  a_bHold: assert property (p_bHold) else $error("write answer not held");
endmodule // rtxt_timing_chk
bind rtxt_timing_regs rtxt_timing_chk rtxt_timing_chk_inst (.clk(clk), .reset(reset), .enable(enable),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .modStart(modStart), .txLaunch(txLaunch), .modPulse(modPulse), .silenceIrq(silenceIrq));

// >>> rtxt_tag_model.sv
// tag model that answers lag clock cycles after the transmit end of frame
`timescale 1ns/1ns
module rtxt_tag_model (
  input wire clk,
  input wire txEofEnd,
  input wire answer,
  input wire [7:0] lag,
  output reg tagResponseStart
);
  reg [8:0] cnt;
  initial begin
    cnt = 9'h0;
    tagResponseStart = 1'b0;
  end
  // a silent tag never answers, so the reader has to time the slot out
  always @(posedge clk) begin
    tagResponseStart <= 1'b0;
    if (txEofEnd && answer) begin
      cnt <= {1'b0, lag};
    end else if (cnt != 9'h0) begin
      cnt <= cnt - 9'h1;
      tagResponseStart <= (cnt == 9'h1);
    end
  end
endmodule // rtxt_tag_model

// >>> tb_top.sv
// self-checking bench for the timing register block
`timescale 1ns/1ns
module tb_top;
  reg clk, reset, enable, awv, wv, bry, arv, rry, answer;
  reg [7:0] aw, ar;
  reg [31:0] wd, d;
  reg [6:0] ev;
  reg [1:0] rsp;
  reg [23:0] r;
  wire awr, wrdy, bv, arr, rv, tagResp, txLaunch, modPulse, irq;
  wire [1:0] br, rr;
  wire [31:0] rd;
  integer bad_count, n_tests, n, i;
  // row: protocol code, silence preset (time / 37.76 us), pulse cycles (ceil of time / 10 ns)
  localparam [167:0] ROWS = {24'hF0E3B0, 24'h50E02D, 24'h40E04A, 24'h30E08C, 24'h20E0EC, 24'h1143B0, 24'h0303B0};
  rtxt_timing_regs rtxt_timing_regs_inst (.clk(clk), .reset(reset), .enable(enable),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .txSofBegin(ev[0]), .txSofEnd(ev[1]), .rxSofBegin(ev[2]),
    .rxSofEnd(ev[3]), .txStartReq(ev[4]), .txEofEnd(ev[5]), .modStart(ev[6]),
    .tagResponseStart(tagResp), .txLaunch(txLaunch), .modPulse(modPulse), .silenceIrq(irq));
  rtxt_tag_model rtxt_tag_model_inst (.clk(clk), .txEofEnd(ev[5]), .answer(answer), .lag(8'h64),
    .tagResponseStart(tagResp));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task axiWr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      aw <= a;
      wd <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      rsp = br;
      bry <= 1'b0;
    end
  endtask
  task axiRd(input [7:0] a);
    begin
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      d = rd;
      rsp = rr;
      rry <= 1'b0;
    end
  endtask
  task rdChk(input [7:0] a, input [31:0] exp);
    begin
      axiRd(a);
      chk(d, exp);
    end
  endtask
  task fire(input [6:0] e);
    begin
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 7'h0;
      #1;
      n = 0;
    end
  endtask
  // counts edges after the event until launch, pulse end or flag
  task waitFor(input [1:0] s, input integer lim);
    begin
      while (!(s == 0 ? txLaunch === 1'b1 : s == 1 ? modPulse === 1'b0 : irq === 1'b1) && n < lim) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  task wrap_up;
    begin
      if (bad_count == 0 && n_tests > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #800000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    reset = 1'b1;
    enable = 1'b1;
    {awv, wv, bry, arv, rry, answer} = 6'h00;
    {aw, ar, wd, ev} = 55'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdChk(8'h14, 32'h0);
    rdChk(8'h18, 32'h0);
    rdChk(8'h1C, 32'h0E);
    rdChk(8'h10, 32'hC2);
    for (i = 0; i < 7; i = i + 1) begin
      r = ROWS[i*24 +: 24];
      axiWr(8'h14, 8'hA5);
      axiWr(8'h18, 8'h5A);
      axiWr(8'h1C, 8'h99);
      axiWr(8'h10, 8'h3F);
      axiWr(8'h04, {4'h0, r[23:20]});
      rdChk(8'h14, 32'h0);
      rdChk(8'h18, 32'h0);
      rdChk(8'h1C, {24'h0, r[19:12]});
      rdChk(8'h10, 32'hC2);
      fire(7'h40);
      waitFor(1, 2000);
      chk(n, r[11:0]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      axiWr(8'h10, i == 4 ? 8'h01 : {i[1:0], 6'h0});
      axiWr(8'h14, i == 4 ? 8'h00 : i[7:0] + 8'h01);
      fire(7'h10);
      fire(7'h01 << i[1:0]);
      waitFor(0, 16000);
      chk(n, i == 4 ? 256 * 59 : (i + 1) * 59);
    end
    axiWr(8'h10, 8'h00);
    axiWr(8'h14, 8'h00);
    fire(7'h10);
    waitFor(0, 5);
    chk(n <= 1, 1);
    axiWr(8'h18, 8'h01);
    fire(7'h40);
    waitFor(1, 100);
    chk(n, 8);
    axiWr(8'h18, 8'hFF);
    fire(7'h40);
    waitFor(1, 3000);
    chk(n, 1880);
    axiWr(8'h04, 8'h01);
    axiWr(8'h1C, 8'h01);
    fire(7'h20);
    waitFor(2, 5000);
    chk(n, 3776);
    rdChk(8'h30, 32'h1);
    chk(irq, 0);
    answer <= 1'b1;
    fire(7'h20);
    waitFor(2, 4500);
    chk(n, 4500);
    axiWr(8'h04, 8'h02);
    axiWr(8'h1C, 8'h01);
    answer <= 1'b0;
    fire(7'h20);
    waitFor(2, 4500);
    chk(n, 4500);
    axiWr(8'h14, 8'h33);
    axiWr(8'h18, 8'h33);
    @(posedge clk);
    enable <= 1'b0;
    repeat (3) @(posedge clk);
    enable <= 1'b1;
    rdChk(8'h14, 32'h0);
    rdChk(8'h18, 32'h0);
    rdChk(8'h1C, 32'h0E);
    axiRd(8'hFC);
    chk(d, 32'h00000000);
    chk(rsp, 2'h2);
    axiWr(8'hFC, 8'h00);
    chk(rsp, 2'h2);
    wrap_up;
  end
endmodule // tb_top
